/* File: dtbsc_top.v */
// Two TAPs chained between TDI and TDO, sampled on the reference clock.
// Assumes TCK, TMS and TDI arrive asynchronously and TCK is far slower than i_ref_clk.
`timescale 1ns/1ps
`include "dtbsc_map.vh"

module dtbsc_top #(
	parameter BSR_W = `DTBSC_BSR_W
) (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_tck,
	input wire i_tms,
	input wire i_tdi,
	input wire [BSR_W-1:0] i_pin_state,
	output reg o_tdo,
	output reg o_tdo_oe_n,
	output wire [BSR_W-1:0] o_pin_preload,
	output reg o_pin_extest,
	output reg o_pin_highz
);
	localparam IR1_W = `DTBSC_IR1_W;
	localparam IR2_W = `DTBSC_IR2_W;
	localparam ID_W = `DTBSC_ID_W;
	localparam BYP_W = `DTBSC_BYP_W;

	// ****************************************
	// Reset release
	// ****************************************
	reg rst_s1_reg;
	reg rst_s2_reg;
	wire rst_n;

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end

	assign rst_n = rst_s2_reg;

	// ****************************************
	// Pin synchronisers and TCK edges
	// ****************************************
	// TMS and TDI settle high like the pad pull-ups while in reset
	reg tck_s1_reg;
	reg tck_s2_reg;
	reg tck_d_reg;
	reg tms_s1_reg;
	reg tms_s2_reg;
	reg tdi_s1_reg;
	reg tdi_s2_reg;
	wire tck_rise;
	wire tck_fall;

	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tck_s1_reg <= 1'b0;
			tck_s2_reg <= 1'b0;
			tck_d_reg <= 1'b0;
			tms_s1_reg <= 1'b1;
			tms_s2_reg <= 1'b1;
			tdi_s1_reg <= 1'b1;
			tdi_s2_reg <= 1'b1;
		end else begin
			tck_s1_reg <= i_tck;
			tck_s2_reg <= tck_s1_reg;
			tck_d_reg <= tck_s2_reg;
			tms_s1_reg <= i_tms;
			tms_s2_reg <= tms_s1_reg;
			tdi_s1_reg <= i_tdi;
			tdi_s2_reg <= tdi_s1_reg;
		end
	end

	// Same latency on all three pins keeps TMS and TDI aligned with the TCK rise
	assign tck_rise = tck_s2_reg & ~tck_d_reg;
	assign tck_fall = ~tck_s2_reg & tck_d_reg;

	// ****************************************
	// TAP controllers
	// ****************************************
	// Both controllers see the same TMS, so they stay in lock step
	wire [1:0] tlr;
	wire [1:0] cap_dr;
	wire [1:0] sh_dr;
	wire [1:0] upd_dr;
	wire [1:0] cap_ir;
	wire [1:0] sh_ir;
	wire [1:0] upd_ir;

	genvar t;
	generate
		for (t = 0; t < 2; t = t + 1) begin : g_tap
			dtbsc_tap_fsm u_fsm (
				.i_clk(i_ref_clk),
				.i_rst_n(rst_n),
				.i_step(tck_rise),
				.i_tms(tms_s2_reg),
				.o_tlr(tlr[t]),
				.o_cap_dr(cap_dr[t]),
				.o_sh_dr(sh_dr[t]),
				.o_upd_dr(upd_dr[t]),
				.o_cap_ir(cap_ir[t]),
				.o_sh_ir(sh_ir[t]),
				.o_upd_ir(upd_ir[t])
			);
		end
	endgenerate

	// ****************************************
	// Instruction registers
	// ****************************************
	wire ir1_so;
	wire ir2_so;
	wire [IR1_W-1:0] ir1;
	wire [IR2_W-1:0] ir2;

	// IR path runs TDI into the first TAP, then through the second to TDO
	dtbsc_shreg #(
		.W(IR1_W),
		.RST(`DTBSC_IR1_IDCODE),
		.CAP_RST(`DTBSC_IR1_CAP)
	) u_ir1 (
		.i_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.i_step(tck_rise),
		.i_capture(cap_ir[0]),
		.i_shift(sh_ir[0]),
		.i_update(upd_ir[0]),
		.i_tlr(tlr[0]),
		.i_si(tdi_s2_reg),
		.i_cap(`DTBSC_IR1_CAP),
		.o_so(ir1_so),
		.o_upd(ir1)
	);

	dtbsc_shreg #(
		.W(IR2_W),
		.RST(`DTBSC_IR2_IDCODE),
		.CAP_RST(`DTBSC_IR2_CAP)
	) u_ir2 (
		.i_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.i_step(tck_rise),
		.i_capture(cap_ir[1]),
		.i_shift(sh_ir[1]),
		.i_update(upd_ir[1]),
		.i_tlr(tlr[1]),
		.i_si(ir1_so),
		.i_cap(`DTBSC_IR2_CAP),
		.o_so(ir2_so),
		.o_upd(ir2)
	);

	// ****************************************
	// Instruction decode
	// ****************************************
	// Unknown opcodes fall back to bypass so the chain never breaks
	wire t1_id;
	wire t1_byp;
	wire t2_id;
	wire t2_bsr;
	wire t2_byp;
	wire t2_extest;
	wire t2_highz;

	assign t1_id = (ir1 == `DTBSC_IR1_IDCODE);
	assign t1_byp = ~t1_id;
	assign t2_extest = (ir2 == `DTBSC_IR2_EXTEST);
	assign t2_highz = (ir2 == `DTBSC_IR2_HIGHZ);
	assign t2_id = (ir2 == `DTBSC_IR2_IDCODE);
	assign t2_bsr = t2_extest | (ir2 == `DTBSC_IR2_SAMPLE);
	assign t2_byp = ~t2_id & ~t2_bsr;

	// ****************************************
	// First TAP data registers
	// ****************************************
	wire id1_so;
	wire byp1_so;
	wire t1_so;

	dtbsc_shreg #(
		.W(ID_W)
	) u_id1 (
		.i_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.i_step(tck_rise),
		.i_capture(cap_dr[0] & t1_id),
		.i_shift(sh_dr[0] & t1_id),
		.i_update(1'b0),
		.i_tlr(1'b0),
		.i_si(tdi_s2_reg),
		.i_cap(`DTBSC_ID1_VAL),
		.o_so(id1_so),
		.o_upd()
	);

	dtbsc_shreg #(
		.W(BYP_W)
	) u_byp1 (
		.i_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.i_step(tck_rise),
		.i_capture(cap_dr[0] & t1_byp),
		.i_shift(sh_dr[0] & t1_byp),
		.i_update(1'b0),
		.i_tlr(1'b0),
		.i_si(tdi_s2_reg),
		.i_cap(`DTBSC_BYP_CAP),
		.o_so(byp1_so),
		.o_upd()
	);

	assign t1_so = t1_id ? id1_so : byp1_so;

	// ****************************************
	// Second TAP data registers
	// ****************************************
	wire id2_so;
	wire byp2_so;
	wire bsr_so;
	wire t2_so;

	dtbsc_shreg #(
		.W(ID_W)
	) u_id2 (
		.i_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.i_step(tck_rise),
		.i_capture(cap_dr[1] & t2_id),
		.i_shift(sh_dr[1] & t2_id),
		.i_update(1'b0),
		.i_tlr(1'b0),
		.i_si(t1_so),
		.i_cap(`DTBSC_ID2_VAL),
		.o_so(id2_so),
		.o_upd()
	);

	dtbsc_shreg #(
		.W(BYP_W)
	) u_byp2 (
		.i_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.i_step(tck_rise),
		.i_capture(cap_dr[1] & t2_byp),
		.i_shift(sh_dr[1] & t2_byp),
		.i_update(1'b0),
		.i_tlr(1'b0),
		.i_si(t1_so),
		.i_cap(`DTBSC_BYP_CAP),
		.o_so(byp2_so),
		.o_upd()
	);

	// Update latch holds the preload pattern across later instructions
	dtbsc_shreg #(
		.W(BSR_W)
	) u_bsr (
		.i_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.i_step(tck_rise),
		.i_capture(cap_dr[1] & t2_bsr),
		.i_shift(sh_dr[1] & t2_bsr),
		.i_update(upd_dr[1] & t2_bsr),
		.i_tlr(1'b0),
		.i_si(t1_so),
		.i_cap(i_pin_state),
		.o_so(bsr_so),
		.o_upd(o_pin_preload)
	);

	assign t2_so = t2_id ? id2_so : (t2_bsr ? bsr_so : byp2_so);

	// ****************************************
	// Pin control
	// ****************************************
	// Registered so the pin muxes never see a decode glitch
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_pin_extest <= 1'b0;
			o_pin_highz <= 1'b0;
		end else begin
			o_pin_extest <= t2_extest;
			o_pin_highz <= t2_highz;
		end
	end

	// ****************************************
	// TDO on the falling TCK edge
	// ****************************************
	wire shifting;
	wire chain_out;

	assign shifting = sh_dr[1] | sh_ir[1];
	assign chain_out = sh_ir[1] ? ir2_so : t2_so;

	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_tdo <= 1'b0;
			o_tdo_oe_n <= 1'b1;
		end else if (tck_fall) begin
			o_tdo <= shifting ? chain_out : o_tdo;
			o_tdo_oe_n <= ~shifting;
		end
	end
endmodule

/* File: dtbsc_map.vh */
// Constants of the dual-TAP boundary-scan chain: opcodes, lengths, reset values.
// Assumes inclusion by bare name from each design file that uses its macros.
`ifndef DTBSC_MAP_VH
`define DTBSC_MAP_VH

// ****************************************
// Instruction and data register lengths
// ****************************************
`define DTBSC_IR1_W 3
`define DTBSC_IR2_W 8
`define DTBSC_ID_W 32
`define DTBSC_BYP_W 1
`define DTBSC_BSR_W 32

// ****************************************
// First TAP opcodes
// ****************************************
`define DTBSC_IR1_BYPASS 3'h7
`define DTBSC_IR1_IDCODE 3'h1

// ****************************************
// Second TAP opcodes
// ****************************************
`define DTBSC_IR2_BYPASS 8'hFF
`define DTBSC_IR2_EXTEST 8'h00
`define DTBSC_IR2_SAMPLE 8'h01
`define DTBSC_IR2_HIGHZ 8'h07
`define DTBSC_IR2_IDCODE 8'h02

// ****************************************
// Capture and reset values
// ****************************************
// Identification codes: arbitrary values, bit 0 set as usual for ID registers
`define DTBSC_ID1_VAL 32'h0ABC0001
`define DTBSC_ID2_VAL 32'h00DE5001
`define DTBSC_IR1_CAP 3'h1
`define DTBSC_IR2_CAP 8'h01
`define DTBSC_BYP_CAP 1'h0

// ****************************************
// TAP controller state codes
// ****************************************
`define DTBSC_ST_TLR 4'hF
`define DTBSC_ST_RTI 4'hC
`define DTBSC_ST_SEL_DR 4'h7
`define DTBSC_ST_CAP_DR 4'h6
`define DTBSC_ST_SH_DR 4'h2
`define DTBSC_ST_EX1_DR 4'h1
`define DTBSC_ST_PAU_DR 4'h3
`define DTBSC_ST_EX2_DR 4'h0
`define DTBSC_ST_UPD_DR 4'h5
`define DTBSC_ST_SEL_IR 4'h4
`define DTBSC_ST_CAP_IR 4'hE
`define DTBSC_ST_SH_IR 4'hA
`define DTBSC_ST_EX1_IR 4'h9
`define DTBSC_ST_PAU_IR 4'hB
`define DTBSC_ST_EX2_IR 4'h8
`define DTBSC_ST_UPD_IR 4'hD

`endif

/* File: dtbsc_tap_fsm.v */
// Sixteen-state TAP controller, advanced once per test clock rising edge.
// Assumes i_step is a one-cycle pulse on the reference clock at each TCK rise.
`timescale 1ns/1ps
`include "dtbsc_map.vh"

module dtbsc_tap_fsm (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_step,
	input wire i_tms,
	output wire o_tlr,
	output wire o_cap_dr,
	output wire o_sh_dr,
	output wire o_upd_dr,
	output wire o_cap_ir,
	output wire o_sh_ir,
	output wire o_upd_ir
);
	localparam TLR = `DTBSC_ST_TLR;
	localparam RTI = `DTBSC_ST_RTI;
	localparam SEL_DR = `DTBSC_ST_SEL_DR;
	localparam CAP_DR = `DTBSC_ST_CAP_DR;
	localparam SH_DR = `DTBSC_ST_SH_DR;
	localparam EX1_DR = `DTBSC_ST_EX1_DR;
	localparam PAU_DR = `DTBSC_ST_PAU_DR;
	localparam EX2_DR = `DTBSC_ST_EX2_DR;
	localparam UPD_DR = `DTBSC_ST_UPD_DR;
	localparam SEL_IR = `DTBSC_ST_SEL_IR;
	localparam CAP_IR = `DTBSC_ST_CAP_IR;
	localparam SH_IR = `DTBSC_ST_SH_IR;
	localparam EX1_IR = `DTBSC_ST_EX1_IR;
	localparam PAU_IR = `DTBSC_ST_PAU_IR;
	localparam EX2_IR = `DTBSC_ST_EX2_IR;
	localparam UPD_IR = `DTBSC_ST_UPD_IR;

	reg [3:0] state_reg;
	reg [3:0] state_next;

	// ****************************************
	// Next-state graph
	// ****************************************
	always @* begin
		case (state_reg)
			TLR: state_next = i_tms ? TLR : RTI;
			RTI: state_next = i_tms ? SEL_DR : RTI;
			SEL_DR: state_next = i_tms ? SEL_IR : CAP_DR;
			CAP_DR: state_next = i_tms ? EX1_DR : SH_DR;
			SH_DR: state_next = i_tms ? EX1_DR : SH_DR;
			EX1_DR: state_next = i_tms ? UPD_DR : PAU_DR;
			PAU_DR: state_next = i_tms ? EX2_DR : PAU_DR;
			EX2_DR: state_next = i_tms ? UPD_DR : SH_DR;
			UPD_DR: state_next = i_tms ? SEL_DR : RTI;
			SEL_IR: state_next = i_tms ? TLR : CAP_IR;
			CAP_IR: state_next = i_tms ? EX1_IR : SH_IR;
			SH_IR: state_next = i_tms ? EX1_IR : SH_IR;
			EX1_IR: state_next = i_tms ? UPD_IR : PAU_IR;
			PAU_IR: state_next = i_tms ? EX2_IR : PAU_IR;
			EX2_IR: state_next = i_tms ? UPD_IR : SH_IR;
			UPD_IR: state_next = i_tms ? SEL_DR : RTI;
			default: state_next = TLR;
		endcase
	end

	// Moves only on a TCK rise, so the ref clock never outruns the tester
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= TLR;
		end else if (i_step) begin
			state_reg <= state_next;
		end
	end

	assign o_tlr = (state_reg == TLR);
	assign o_cap_dr = (state_reg == CAP_DR);
	assign o_sh_dr = (state_reg == SH_DR);
	assign o_upd_dr = (state_reg == UPD_DR);
	assign o_cap_ir = (state_reg == CAP_IR);
	assign o_sh_ir = (state_reg == SH_IR);
	assign o_upd_ir = (state_reg == UPD_IR);
endmodule

/* File: dtbsc_shreg.v */
// Scan register cell row: capture, right shift from the MSB, update latch.
// Assumes capture, shift and update levels come from the TAP controller state.
`timescale 1ns/1ps

module dtbsc_shreg #(
	parameter W = 1,
	parameter [W-1:0] RST = {W{1'b0}},
	parameter [W-1:0] CAP_RST = {W{1'b0}}
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_step,
	input wire i_capture,
	input wire i_shift,
	input wire i_update,
	input wire i_tlr,
	input wire i_si,
	input wire [W-1:0] i_cap,
	output wire o_so,
	output reg [W-1:0] o_upd
);
	reg [W-1:0] sr_reg;
	wire [W-1:0] sr_shifted;

	// ****************************************
	// Shift stage
	// ****************************************
	generate
		if (W > 1) begin : g_wide
			assign sr_shifted = {i_si, sr_reg[W-1:1]};
		end else begin : g_one
			assign sr_shifted = i_si;
		end
	endgenerate

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sr_reg <= CAP_RST;
		end else if (i_step && i_capture) begin
			sr_reg <= i_cap;
		end else if (i_step && i_shift) begin
			sr_reg <= sr_shifted;
		end
	end

	// ****************************************
	// Update latch
	// ****************************************
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_upd <= RST;
		end else if (i_tlr) begin
			// Held while in the reset state, so entry alone restores the default
			o_upd <= RST;
		end else if (i_step && i_update) begin
			o_upd <= sr_reg;
		end
	end

	assign o_so = sr_reg[0];
endmodule

/* File: dtbsc_chk.sv */
// Checker for the dual-TAP scan chain, watching only the top module's ports.
// Assumes TCK is far slower than i_ref_clk, each phase lasting at least 8 cycles.
`timescale 1ns/1ps

module dtbsc_chk #(
	parameter BSR_W = 32
) (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_tck,
	input wire i_tms,
	input wire i_tdi,
	input wire [BSR_W-1:0] i_pin_state,
	input wire o_tdo,
	input wire o_tdo_oe_n,
	input wire [BSR_W-1:0] o_pin_preload,
	input wire o_pin_extest,
	input wire o_pin_highz
);
	// ****************************************
	// Helper logic
	// ****************************************
	reg [1:0] tck_hist_reg;
	reg [2:0] tms_cnt_reg;
	wire tck_rise;
	assign tck_rise = tck_hist_reg[0] & ~tck_hist_reg[1];
	// Counts consecutive TCK rises with TMS high, saturating at five
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tck_hist_reg <= 2'h0;
			tms_cnt_reg <= 3'h0;
		end else begin
			tck_hist_reg <= {tck_hist_reg[0], i_tck};
			if (tck_rise && !i_tms)
				tms_cnt_reg <= 3'h0;
			else if (tck_rise && tms_cnt_reg != 3'h5)
				tms_cnt_reg <= tms_cnt_reg + 3'h1;
		end
	end
	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	property p_tdo_fall;
		$changed(o_tdo) |-> !i_tck;
	endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("TDO changed with TCK high");
	property p_oe_fall;
		$changed(o_tdo_oe_n) |-> !i_tck;
	endproperty
	a_oe_fall: assert property (p_oe_fall) else $error("TDO enable changed with TCK high");
	property p_rise_quiet;
		tck_rise |-> ##1 ($stable(o_tdo) && $stable(o_tdo_oe_n)) [*4];
	endproperty
	a_rise_quiet: assert property (p_rise_quiet) else $error("TDO moved after TCK rise");
	property p_oe_stand;
		$fell(o_tdo_oe_n) |-> (!o_tdo_oe_n) [*8];
	endproperty
	a_oe_stand: assert property (p_oe_stand) else $error("TDO enable dropped early");
	property p_tlr;
		tms_cnt_reg == 3'h5 |-> ##6 (!o_pin_extest && !o_pin_highz);
	endproperty
	a_tlr: assert property (p_tlr) else $error("Five TMS highs left a test mode on");
	property p_excl;
		o_pin_highz |-> !o_pin_extest;
	endproperty
	a_excl: assert property (p_excl) else $error("High-Z and external test both on");
	property p_pre;
		$changed(o_pin_preload) |-> i_tck;
	endproperty
	a_pre: assert property (p_pre) else $error("Preload latch moved off a TCK rise");
	property p_mode;
		($changed(o_pin_extest) || $changed(o_pin_highz)) |-> i_tck;
	endproperty
	a_mode: assert property (p_mode) else $error("Pin mode moved off a TCK rise");
	c_shift: cover property (!o_tdo_oe_n);
	c_ext: cover property (o_pin_extest);
	c_hz: cover property (o_pin_highz);
	c_tlr: cover property (tms_cnt_reg == 3'h5);
endmodule

bind dtbsc_top dtbsc_chk #(.BSR_W(BSR_W)) u_chk (
	.i_ref_clk(i_ref_clk),
	.i_rst_n(i_rst_n),
	.i_tck(i_tck),
	.i_tms(i_tms),
	.i_tdi(i_tdi),
	.i_pin_state(i_pin_state),
	.o_tdo(o_tdo),
	.o_tdo_oe_n(o_tdo_oe_n),
	.o_pin_preload(o_pin_preload),
	.o_pin_extest(o_pin_extest),
	.o_pin_highz(o_pin_highz)
);

/* File: dtbsc_jtag_model.sv */
// External test controller model: drives TCK, TMS, TDI and samples TDO.
// Assumes a 100 MHz reference clock; one TCK bit takes 16 cycles (160 ns).
`timescale 1ns/1ps

module dtbsc_jtag_model (
	input wire i_ref_clk,
	input wire i_tdo,
	input wire i_tdo_oe_n,
	output reg o_tck,
	output reg o_tms,
	output reg o_tdi
);
	reg tdo_last;
	wire tdo_wire;
	// Released TDO shows the inverse of its last value, so stale data never matches
	assign tdo_wire = i_tdo_oe_n ? ~tdo_last : i_tdo;
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b1;
		tdo_last = 1'b0;
	end
	always @(posedge i_ref_clk) begin
		if (!i_tdo_oe_n)
			tdo_last <= i_tdo;
	end
	// TCK stands high between bits; TDO is read late in the low phase
	task automatic tbit(input logic tms, input logic tdi, output logic tdo);
		begin
			@(posedge i_ref_clk);
			o_tck <= 1'b0;
			o_tms <= tms;
			o_tdi <= tdi;
			repeat (7) @(posedge i_ref_clk);
			tdo = tdo_wire;
			@(posedge i_ref_clk);
			o_tck <= 1'b1;
			repeat (7) @(posedge i_ref_clk);
		end
	endtask
	task automatic tap_reset;
		logic d;
		begin
			repeat (5) tbit(1'b1, 1'b1, d);
			tbit(1'b0, 1'b1, d);
		end
	endtask
	// From Run-Test/Idle through one DR or IR scan and back
	task automatic scan(input logic ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		logic d;
		begin
			dout = 64'h0;
			tbit(1'b1, 1'b1, d);
			if (ir)
				tbit(1'b1, 1'b1, d);
			tbit(1'b0, 1'b1, d);
			tbit(1'b0, 1'b1, d);
			for (int i = 0; i < n; i++) begin
				tbit(i == n - 1, din[i], d);
				dout[i] = d;
			end
			tbit(1'b1, 1'b1, d);
			tbit(1'b0, 1'b1, d);
		end
	endtask
endmodule

/* File: tb.sv */
// Self-checking bench: a queue model of the selected chain predicts every data scan.
// Assumes the controller model in dtbsc_jtag_model drives the whole link.
`timescale 1ns/1ps
`include "dtbsc_map.vh"

module tb;
	localparam int BW = 8;
	localparam logic [31:0] ID1 = `DTBSC_ID1_VAL;
	localparam logic [31:0] ID2 = `DTBSC_ID2_VAL;
	reg i_ref_clk = 1'b0;
	reg i_rst_n = 1'b0;
	reg [BW-1:0] pins = 8'h00;
	wire tck, tms, tdi, tdo, tdo_oe_n, extest, highz;
	wire [BW-1:0] preload;
	int n_errors = 0;
	int checks_done = 0;
	logic [31:0] lfsr = 32'hDF04;
	logic [7:0] m_op;
	logic [BW-1:0] m_pre;
	logic [63:0] d;
	// Ends on external test so the TAP reset must clear a live pin mode
	logic [7:0] ops [5] = '{8'hFF, 8'h01, 8'h07, 8'h01, 8'h00};

	dtbsc_top #(.BSR_W(BW)) dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_tck(tck),
		.i_tms(tms), .i_tdi(tdi), .i_pin_state(pins), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n),
		.o_pin_preload(preload), .o_pin_extest(extest), .o_pin_highz(highz));
	dtbsc_jtag_model u_jtag (.i_ref_clk(i_ref_clk), .i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n),
		.o_tck(tck), .o_tms(tms), .o_tdi(tdi));

	initial begin
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
		begin
			checks_done++;
			if (got !== exp) begin
				n_errors++;
				$display("MISMATCH %s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	task automatic final_report;
		begin
			if (n_errors == 0 && checks_done > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	// Instruction scan: TAP2 opcode first, then bypass for TAP1
	task automatic set_ir(input logic [7:0] op);
		begin
			u_jtag.scan(1'b1, 11, {53'h0, 3'b111, op}, d);
			check("ir_capture", {53'h0, 3'b001, 8'h01}, d);
			m_op = op;
		end
	endtask
	// Data scan of the whole chain, with new pin values to capture
	task automatic dr_scan;
		logic q[$];
		logic [63:0] din, exp;
		logic [BW-1:0] pv;
		int n;
		begin
			@(posedge i_ref_clk);
			pv = BW'(rnd());
			pins <= pv;
			q = {};
			din = {rnd(), rnd()};
			if (m_op == `DTBSC_IR2_IDCODE) begin
				for (int i = 0; i < 32; i++)
					q.push_back(ID2[i]);
				for (int i = 0; i < 32; i++)
					q.push_back(ID1[i]);
				n = 64;
			end else if (m_op == `DTBSC_IR2_SAMPLE || m_op == `DTBSC_IR2_EXTEST) begin
				for (int i = 0; i < BW; i++)
					q.push_back(pv[i]);
				q.push_back(1'b0);
				n = BW + 1;
			end else begin
				q.push_back(1'b0);
				q.push_back(1'b0);
				// Runs past the two bypass bits so shifted-in data must come back out
				n = 10;
			end
			exp = 64'h0;
			for (int i = 0; i < n; i++) begin
				exp[i] = q[0];
				q.push_back(din[i]);
				q.pop_front();
			end
			u_jtag.scan(1'b0, n, din, d);
			check("dr_out", exp, d);
			if (m_op == `DTBSC_IR2_SAMPLE || m_op == `DTBSC_IR2_EXTEST) begin
				for (int i = 0; i < BW; i++)
					m_pre[i] = q[i];
				check("preload", m_pre, preload);
			end
			check("extest", m_op == `DTBSC_IR2_EXTEST, extest);
			check("highz", m_op == `DTBSC_IR2_HIGHZ, highz);
		end
	endtask

	initial begin
		repeat (100000) @(posedge i_ref_clk);
		n_errors++;
		final_report();
	end
	initial begin
		repeat (10) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		repeat (8) @(posedge i_ref_clk);
		m_op = `DTBSC_IR2_IDCODE;
		u_jtag.tbit(1'b0, 1'b1, d[0]);
		dr_scan();
		foreach (ops[k]) begin
			set_ir(ops[k]);
			dr_scan();
			dr_scan();
		end
		u_jtag.tap_reset();
		m_op = `DTBSC_IR2_IDCODE;
		dr_scan();
		check("preload_kept", m_pre, preload);
		final_report();
	end
endmodule
